// file: eic_pkg.sv
// Package for the external interrupt input control block.
// Assumes an 8-bit special function space access port on the CPU side.
package eic_pkg;

   // ----------------------------------------
   // Address map
   // ----------------------------------------
   localparam logic [11:0] SFS_FIRST    = 12'h000;
   localparam logic [11:0] SFS_LAST     = 12'h03F;
   localparam logic [11:0] DBS_FIRST    = 12'hF80;
   localparam logic [11:0] DBS_LAST     = 12'hFFF;
   localparam logic [11:0] CONTROL_ADDR = 12'h037;
   localparam logic [7:0]  CONTROL_RST  = 8'h00;

   // ----------------------------------------
   // Control register fields
   // ----------------------------------------
   localparam int NOISE_SEL_BIT  = 7;
   localparam int FIRST_SEL_BIT  = 6;
   localparam int FIFTH_ES_HI    = 5;
   localparam int FIFTH_ES_LO    = 4;
   localparam int FOURTH_ES_BIT  = 3;
   localparam int THIRD_ES_BIT   = 2;
   localparam int SECOND_ES_BIT  = 1;

   localparam logic [1:0] FIFTH_RISE  = 2'h0;
   localparam logic [1:0] FIFTH_FALL  = 2'h1;
   localparam logic [1:0] FIFTH_BOTH  = 2'h2;
   localparam logic [1:0] FIFTH_LEVEL = 2'h3;

   // ----------------------------------------
   // Noise reject timing, in high-frequency clock periods
   // ----------------------------------------
   localparam int NOISE_SHORT_FC   = 15;
   localparam int NOISE_LONG_FC    = 63;
   localparam int NOISE_FIRST_FC   = 2;
   localparam int NOISE_OTHER_FC   = 7;
   localparam int NOISE_CHANGE_MAX = 26;
   localparam logic [6:0] CNT_SHORT = 7'(NOISE_SHORT_FC);
   localparam logic [6:0] CNT_LONG  = 7'(NOISE_LONG_FC);
   localparam logic [6:0] CNT_FIRST = 7'(NOISE_FIRST_FC);
   localparam logic [6:0] CNT_OTHER = 7'(NOISE_OTHER_FC);

   typedef struct packed {
      logic       noise_long;
      logic       first_pin_irq_select;
      logic [1:0] fifth_input_edge_sel;
      logic       fourth_input_edge_sel;
      logic       third_input_edge_sel;
      logic       second_input_edge_sel;
      logic       spare;
   } eic_control_type;

   typedef enum logic [1:0] {
      FIFTH_ARMING = 2'b00,
      FIFTH_ARMED  = 2'b01
   } eic_fifth_state_type;

endpackage

// file: eic_top.sv
// External interrupt input control: filters, edge selection and request pulses.
// Assumes pins asynchronous to clk and a CPU access port with one-cycle strobes.
`timescale 1ns/1ps
module eic_top (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [11:0] addr,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   input  wire logic [7:0]  wr_data,
   output logic [7:0]       rd_data,
   output logic             sfs_hit,
   output logic             dbs_hit,
   input  wire logic [5:0]  irq_pin,
   output logic [5:0]       irq_request,
   output logic             shared_port_bit_zero
);

   // ----------------------------------------
   // Register access
   // ----------------------------------------
   eic_pkg::eic_control_type external_irq_control;
   logic [7:0] ctl_bits;
   wire        ctl_sel  = (addr == eic_pkg::CONTROL_ADDR);
   wire        ctl_wr   = wr_en && ctl_sel;
   wire        in_sfs   = (addr <= eic_pkg::SFS_LAST);
   wire        in_dbs   = (addr >= eic_pkg::DBS_FIRST);
   wire [7:0]  next_rd  = (rd_en && ctl_sel) ? ctl_bits : 8'h00;

   assign ctl_bits = external_irq_control;

   // ----------------------------------------
   // Control register and read port
   // ----------------------------------------

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         external_irq_control <= eic_pkg::CONTROL_RST;
      end else if (ctl_wr) begin
         external_irq_control <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 8'h00;
         sfs_hit <= 1'b0;
         dbs_hit <= 1'b0;
      end else begin
         rd_data <= next_rd;
         sfs_hit <= (rd_en || wr_en) && in_sfs;
         dbs_hit <= (rd_en || wr_en) && in_dbs;
      end
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [5:0] sync_a;
   logic [5:0] sync_b;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_a <= 6'h00;
         sync_b <= 6'h00;
      end else begin
         sync_a <= irq_pin;
         sync_b <= sync_a;
      end
   end

   // ----------------------------------------
   // Start-up settling
   // ----------------------------------------
   // Filters take the pin level untimed until the chain is full, so a pin
   // already high at reset release shows no edge
   logic [1:0] warm;
   wire        ready = &warm;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         warm <= 2'h0;
      end else if (!ready) begin
         warm <= warm + 2'h1;
      end
   end

   // ----------------------------------------
   // Noise filters: level must hold for the reject count
   // ----------------------------------------
   logic [5:0] filt;
   logic [5:0] filt_d;
   logic       fifth_seen;

   // Slow-clock windows are not modelled; filters always count clk periods
   // Select bit read live, so a new window applies well inside 26 periods
   function automatic logic [6:0] noise_limit(input int idx, input logic long_sel);
      logic [6:0] lim;
      lim = eic_pkg::CNT_OTHER;
      if (idx == 0 || idx == 1) begin
         lim = eic_pkg::CNT_FIRST;
      end else if (idx == 2) begin
         lim = long_sel ? eic_pkg::CNT_LONG : eic_pkg::CNT_SHORT;
      end
      noise_limit = lim;
   endfunction

   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : gen_filter
         logic [6:0] cnt;
         wire  [6:0] limit  = noise_limit(g, external_irq_control.noise_long);
         wire        differ = (sync_b[g] != filt[g]);
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               cnt     <= 7'h00;
               filt[g] <= 1'b0;
            end else if (!ready) begin
               cnt     <= 7'h00;
               filt[g] <= sync_b[g];
            end else if (!differ) begin
               cnt <= 7'h00;
            end else if (cnt + 7'h01 >= limit) begin
               cnt     <= 7'h00;
               filt[g] <= sync_b[g];
            end else begin
               cnt <= cnt + 7'h01;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         filt_d <= 6'h00;
      end else if (!ready) begin
         // Loaded with the synchroniser output, as the filter is, so no edge is seen while settling
         filt_d <= sync_b;
      end else begin
         filt_d <= filt;
      end
   end

   // ----------------------------------------
   // Edge selection
   // ----------------------------------------
   wire [5:0] rise = filt & ~filt_d;
   wire [5:0] fall = ~filt & filt_d;

   function automatic logic pick_edge(input logic sel, input logic r, input logic f);
      pick_edge = sel ? f : r;
   endfunction

   // ----------------------------------------
   // Fifth input modes
   // ----------------------------------------

   // Fifth input state: level mode only after a rising edge since reset
   eic_pkg::eic_fifth_state_type fifth_state;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fifth_state <= eic_pkg::FIFTH_ARMING;
      end else begin
         case (fifth_state)
            eic_pkg::FIFTH_ARMING: begin
               if (rise[5]) fifth_state <= eic_pkg::FIFTH_ARMED;
            end
            eic_pkg::FIFTH_ARMED: fifth_state <= eic_pkg::FIFTH_ARMED;
            default: fifth_state <= eic_pkg::FIFTH_ARMING;
         endcase
      end
   end
   assign fifth_seen = (fifth_state == eic_pkg::FIFTH_ARMED);

   logic fifth_req;
   always_comb begin
      case (external_irq_control.fifth_input_edge_sel)
         eic_pkg::FIFTH_RISE:  fifth_req = rise[5];
         eic_pkg::FIFTH_FALL:  fifth_req = fall[5];
         eic_pkg::FIFTH_BOTH:  fifth_req = rise[5] | fall[5];
         eic_pkg::FIFTH_LEVEL: fifth_req = filt[5] & (fifth_seen | rise[5]);
         default:              fifth_req = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Request pulses, bit index equals pin index
   // ----------------------------------------
   // Bit0 first (shared pin, falling), bit1 sixth (fixed falling),
   // bits 2-4 second to fourth (one select bit each), bit5 fifth (four modes)
   wire       first_req  = fall[0] & ctl_bits[eic_pkg::FIRST_SEL_BIT];
   wire       sixth_req  = fall[1];
   wire       second_req = pick_edge(ctl_bits[eic_pkg::SECOND_ES_BIT], rise[2], fall[2]);
   wire       third_req  = pick_edge(ctl_bits[eic_pkg::THIRD_ES_BIT], rise[3], fall[3]);
   wire       fourth_req = pick_edge(ctl_bits[eic_pkg::FOURTH_ES_BIT], rise[4], fall[4]);
   wire [5:0] next_req   = {fifth_req, fourth_req, third_req, second_req, sixth_req, first_req};

   // Registered so each request is a clean one-cycle latch-set pulse, except bit5 in level mode,
   // which after a rising edge since reset stays high while the filtered pin is high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_request <= 6'h00;
      end else begin
         irq_request <= next_req;
      end
   end

   // Port view of the first pin; reads zero while the pin serves interrupts
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shared_port_bit_zero <= 1'b0;
      end else begin
         shared_port_bit_zero <= sync_b[0] & ~ctl_bits[eic_pkg::FIRST_SEL_BIT];
      end
   end

endmodule

// file: eic_asserts.sv
// Checker for the external interrupt input block, bound to its top module.
// Assumes one clock and an async active-low reset; sees top ports only.
`timescale 1ns/1ps
module eic_asserts (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic [11:0] addr,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [7:0]  wr_data,
   input wire logic [7:0]  rd_data,
   input wire logic        sfs_hit,
   input wire logic        dbs_hit,
   input wire logic [5:0]  irq_pin,
   input wire logic [5:0]  irq_request,
   input wire logic        shared_port_bit_zero
);
   logic [7:0] ctl;
   logic [6:0] quiet;
   // Shadow of the control value, to tie outputs to the mode in force
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) ctl <= eic_pkg::CONTROL_RST;
      else if (wr_en && addr == eic_pkg::CONTROL_ADDR) ctl <= wr_data;
   end
   // Cycles since any pin moved, saturating
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) quiet <= 7'h00;
      else if (irq_pin != $past(irq_pin)) quiet <= 7'h00;
      else if (quiet != 7'h7F) quiet <= quiet + 7'h01;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sfs_hit_a: assert property (
      sfs_hit == $past((rd_en || wr_en) && addr <= eic_pkg::SFS_LAST)) else $error("bad sfs_hit");
   dbs_hit_a: assert property (
      dbs_hit == $past((rd_en || wr_en) && addr >= eic_pkg::DBS_FIRST)) else $error("bad dbs_hit");
   read_value_a: assert property (
      $past(rd_en && addr == eic_pkg::CONTROL_ADDR) |-> rd_data == $past(ctl))
      else $error("bad read data");
   read_zero_a: assert property (
      !$past(rd_en && addr == eic_pkg::CONTROL_ADDR) |-> rd_data == 8'h00)
      else $error("read data not zero");
   port_irq_a: assert property (irq_request[0] |-> $past(ctl[6]))
      else $error("first request in port mode");
   port_off_a: assert property (ctl[6] && $past(ctl[6]) |-> !shared_port_bit_zero)
      else $error("port bit shown in irq mode");
   single_pulse_a: assert property (
      (irq_request[4:0] & $past(irq_request[4:0])) == 5'h00) else $error("request too long");
   fifth_edge_a: assert property (
      ctl[5:4] != eic_pkg::FIFTH_LEVEL && irq_request[5] |=> !irq_request[5])
      else $error("fifth edge request too long");
   level_keep_a: assert property (
      ctl[5:4] == eic_pkg::FIFTH_LEVEL && irq_pin[5] && quiet >= 7'h14
      && $past(irq_request[5]) |-> irq_request[5]) else $error("level request dropped");
   quiet_pins_a: assert property (
      quiet >= 7'h64 |-> (irq_request & 6'h1F) == 6'h00) else $error("request without edge");
   cover property (irq_request[2]);
   cover property (ctl[5:4] == eic_pkg::FIFTH_LEVEL && irq_request[5]);
   cover property (rd_en && addr == eic_pkg::CONTROL_ADDR);
endmodule
bind eic_top eic_asserts chk (.clk, .rst_n, .addr, .wr_en, .rd_en, .wr_data, .rd_data,
   .sfs_hit, .dbs_hit, .irq_pin, .irq_request, .shared_port_bit_zero);

// file: eic_pin_model.sv
// External signal sources on the interrupt pins.
// Assumes the caller steps pins one at a time; first pin idles high.
`timescale 1ns/1ps
module eic_pin_model (
   input  wire logic       clk,
   output logic      [5:0] irq_pin
);
   initial irq_pin = 6'h01;
   task automatic set(input int i, input logic v);
      @(posedge clk);
      irq_pin[i] <= v;
   endtask
endmodule

// file: tb_external_irq_input_control.sv
// Self-checking bench: register access, edge modes, noise reject, reset arming.
// Assumes the pin model holds every pin steady between calls.
`timescale 1ns/1ps
module tb_external_irq_input_control;
   localparam logic [11:0] CA = eic_pkg::CONTROL_ADDR;
   logic        clk = 0;
   logic        rst_n = 0;
   logic        wr_en = 0;
   logic        rd_en = 0;
   logic [11:0] addr = 12'h000;
   logic [7:0]  wr_data = 8'h00;
   logic [7:0]  rd_data;
   logic        sfs_hit;
   logic        dbs_hit;
   logic        port0;
   logic [5:0]  irq_pin;
   logic [5:0]  irq_request;
   int          fails = 0;
   int          checks = 0;
   int          cnt;
   int          t;
   logic [11:0] ad[5] = '{12'h000, 12'h03F, 12'h040, 12'hFFF, 12'hF7F};
   logic [7:0]  hx[5] = '{8'h02, 8'h02, 8'h00, 8'h01, 8'h00};
   logic [7:0]  rx[4] = '{8'h01, 8'h00, 8'h01, 8'h02};
   logic [7:0]  fx[4] = '{8'h00, 8'h01, 8'h01, 8'h02};
   logic [7:0]  nc[4] = '{8'h00, 8'h00, 8'h80, 8'h80};
   int          nw[4] = '{10, 49, 45, 193};
   logic [7:0]  nx[4] = '{8'h00, 8'h01, 8'h00, 8'h01};
   always #5 clk = ~clk;
   eic_pin_model pins (.clk(clk), .irq_pin(irq_pin));
   eic_top dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
      .wr_data(wr_data), .rd_data(rd_data), .sfs_hit(sfs_hit), .dbs_hit(dbs_hit),
      .irq_pin(irq_pin), .irq_request(irq_request), .shared_port_bit_zero(port0));
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Whole-register writes only, no read-modify-write
   // Pins rest while control is rewritten results taken after the answering edge
   task automatic access(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= w;
      rd_en <= !w;
      @(posedge clk);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      #1;
   endtask
   // Counts request pulses; level mode shows as the clamped value 2
   task automatic drive(input int i, input logic v, input int n);
      pins.set(i, v);
      cnt = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (irq_request[i] === 1'b1) cnt++;
      end
      if (cnt > 2) cnt = 2;
   endtask
   task automatic complete_run;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      access(0, CA, 8'h00);
      cmp(rd_data, eic_pkg::CONTROL_RST);
      // Probe addresses stay clear of reserved slots
      foreach (ad[j]) begin
         access(0, ad[j], 8'h00);
         cmp({6'h00, sfs_hit, dbs_hit}, hx[j]);
      end
      access(1, CA, 8'h5B);
      access(0, CA, 8'h00);
      cmp(rd_data, 8'h5B);
      for (int k = 1; k < 4; k++) begin
         access(1, CA, 8'h00);
         drive(k + 1, 1'b1, 60);
         cmp(8'(cnt), 8'h01);
         drive(k + 1, 1'b0, 60);
         cmp(8'(cnt), 8'h00);
         access(1, CA, 8'(1 << k));
         drive(k + 1, 1'b1, 60);
         cmp(8'(cnt), 8'h00);
         drive(k + 1, 1'b0, 60);
         cmp(8'(cnt), 8'h01);
      end
      for (int m = 0; m < 4; m++) begin
         access(1, CA, 8'(m << 4));
         drive(5, 1'b1, 40);
         cmp(8'(cnt), rx[m]);
         drive(5, 1'b0, 40);
         cmp(8'(cnt), fx[m]);
      end
      foreach (nw[j]) begin
         access(1, CA, nc[j]);
         drive(2, 1'b0, 30); // Settling wait for a new noise time
         drive(2, 1'b1, nw[j]);
         t = cnt;
         drive(2, 1'b0, 220);
         cmp(8'(t + cnt), nx[j]);
      end
      access(1, CA, 8'h00);
      drive(0, 1'b0, 40);
      cmp({7'h00, port0}, 8'h00);
      cmp(8'(cnt), 8'h00);
      drive(0, 1'b1, 40);
      cmp({7'h00, port0}, 8'h01);
      access(1, CA, 8'h40);
      drive(0, 1'b0, 40);
      cmp(8'(cnt), 8'h01);
      drive(0, 1'b1, 40);
      drive(1, 1'b1, 40);
      cmp(8'(cnt), 8'h00);
      drive(1, 1'b0, 40);
      cmp(8'(cnt), 8'h01);
      pins.set(5, 1'b1);
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      access(1, CA, 8'h30);
      drive(5, 1'b1, 60);
      cmp(8'(cnt), 8'h00);
      drive(5, 1'b0, 40);
      drive(5, 1'b1, 40);
      cmp(8'(cnt), 8'h02);
      complete_run();
   end
endmodule
